// ==== shp_pkg.sv ====
// package for the sram-like host port: constants and carrier types
package shp_pkg;

	// host-side timing figures, ns
	localparam int T_CLK_NS      = 8;
	localparam int T_ASSERT_NS   = 32;
	localparam int T_DEASSERT_NS = 13;
	localparam int T_CYCLE_NS    = 45;
	localparam int T_DATA_VAL_NS = 30;

	// least times round up to whole cycles
	localparam int C_ASSERT   = (T_ASSERT_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int C_DEASSERT = (T_DEASSERT_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int C_CYCLE    = (T_CYCLE_NS + T_CLK_NS - 1) / T_CLK_NS;
	// longest time rounds down
	localparam int C_DATA_VAL = T_DATA_VAL_NS / T_CLK_NS;

	// burst limits and field layout
	localparam int BURST_MAX_32 = 8;
	localparam int BURST_MAX_16 = 16;
	localparam int ADDR_W       = 7;
	localparam int WSEL_LSB     = 0;
	localparam int WSEL_W       = 2;
	localparam int REG_LSB      = 2;
	localparam int REG_W        = 5;

	localparam logic [31:0] DATA_RST  = 32'h0000_0000;
	localparam logic [2:0]  SYNC_IDLE = 3'h7;

	typedef enum logic [1:0] {
		SHP_IDLE,
		SHP_READ,
		SHP_WRITE
	} shp_state_e;

	// one decoded access beat
	typedef struct packed {
		logic              fifo_sel;
		logic [ADDR_W-1:0] addr;
		logic              half;
	} shp_req_s;

endpackage

// ==== shp_strobe_sync.sv ====
// two-flop synchroniser for the host strobes and select
`timescale 1ns/1ns
`default_nettype none
module shp_strobe_sync
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// raw strobes, active low: cs, rd, wr
	input  wire logic [2:0] raw_n,
	// synchronised strobes
	output logic [2:0]      sync_n
);
	logic [2:0] meta_q;

	// strobes idle high so reset preloads ones
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= shp_pkg::SYNC_IDLE;
			sync_n <= shp_pkg::SYNC_IDLE;
		end
		else
		begin
			meta_q <= raw_n;
			sync_n <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ==== shp_host_port.sv ====
// sram-like host port slave: read, burst, rx queue direct and write cycles
//
// How it works
// - a read begins when chip select and read strobe are both low and ends when either rises.
// - a write begins when chip select and write strobe are both low and ends when either rises.
// - in a burst the address may change under held strobes, up to 8 words or 16 halves.
// - the port serves a 32-bit bus and optionally a 16-bit bus with the same timing.
// - during any 16-bit read the upper data half is left undriven.
// - during a 16-bit write the upper data half is ignored.
// - with queue select high a read ignores register decode and returns queue data.
// - queue reads still use the low word-address bits and ignore the upper bits.
// - queue bursts have no beat limit, and a released strobe stays high 13 ns.
// - status counters are latched at the start of every read cycle.
`timescale 1ns/1ns
`default_nettype none
module shp_host_port
#(
	parameter int DATA_W = 32
)
(
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// host bus
	input  wire logic              chip_select_n,
	input  wire logic              read_strobe_n,
	input  wire logic              write_strobe_n,
	input  wire logic              fifo_sel,
	input  wire logic [7:1]        addr,
	input  wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0]      data_out,
	output logic [DATA_W-1:0]      data_oe,
	// bus width strap, high for 16-bit bus
	input  wire logic              bus16,
	// register file side
	output logic [6:0]             reg_addr,
	output logic                   reg_rd,
	output logic                   reg_wr,
	output logic [DATA_W-1:0]      reg_wdata,
	output logic                   reg_half,
	input  wire logic [DATA_W-1:0] reg_rdata,
	output logic                   cnt_latch,
	// receive queue side
	input  wire logic [DATA_W-1:0] rxq_data,
	output logic                   rxq_pop,
	output logic [1:0]             rxq_wsel
);
	localparam int HW = DATA_W / 2;

	// ---------------------------------------------------------------
	// strobe synchronisation
	// ---------------------------------------------------------------
	logic [2:0] sync_n;
	logic [2:0] prev_n_q;
	logic [7:1] addr_q;
	logic       sel_q;

	shp_strobe_sync u_sync
	(
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.raw_n   ({chip_select_n, read_strobe_n, write_strobe_n}),
		.sync_n  (sync_n)
	);

	// address and select sampled alongside strobes (same two-stage delay)
	logic [7:1]        addr_m_q;
	logic              sel_m_q;
	// data delayed the same way: the host may drop it as the strobe rises
	logic [DATA_W-1:0] data_m_q;
	logic [DATA_W-1:0] data_q;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev_n_q <= shp_pkg::SYNC_IDLE;
			addr_m_q <= '0;
			addr_q   <= '0;
			sel_m_q  <= 1'b0;
			sel_q    <= 1'b0;
			data_m_q <= shp_pkg::DATA_RST;
			data_q   <= shp_pkg::DATA_RST;
		end
		else
		begin
			prev_n_q <= sync_n;
			addr_m_q <= addr;
			addr_q   <= addr_m_q;
			sel_m_q  <= fifo_sel;
			sel_q    <= sel_m_q;
			data_m_q <= data_in;
			data_q   <= data_m_q;
		end
	end

	// ---------------------------------------------------------------
	// cycle detection
	// ---------------------------------------------------------------
	// read active on both low
	wire rd_act   = !sync_n[2] && !sync_n[1];
	wire rd_was   = !prev_n_q[2] && !prev_n_q[1];
	wire wr_act   = !sync_n[2] && !sync_n[0];
	wire wr_was   = !prev_n_q[2] && !prev_n_q[0];
	wire rd_start = rd_act && !rd_was;
	wire rd_end   = !rd_act && rd_was;
	wire wr_start = wr_act && !wr_was;
	wire wr_end   = !wr_act && wr_was;

	shp_pkg::shp_state_e state_q;
	shp_pkg::shp_state_e state_d;
	shp_pkg::shp_req_s   addr_req_q;
	logic [4:0]          beats_q;

	// address change under held strobes opens a new beat
	wire beat_chg = rd_act && rd_was && (addr_q != addr_req_q.addr
		|| sel_q != addr_req_q.fifo_sel);

	// ---------------------------------------------------------------
	// state machine
	// ---------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			shp_pkg::SHP_IDLE:
				if (rd_start)
					state_d = shp_pkg::SHP_READ;
				else if (wr_start)
					state_d = shp_pkg::SHP_WRITE;
			shp_pkg::SHP_READ:
				if (rd_end)
					state_d = shp_pkg::SHP_IDLE;
			shp_pkg::SHP_WRITE:
				if (wr_end)
					state_d = shp_pkg::SHP_IDLE;
			default:
				state_d = shp_pkg::SHP_IDLE;
		endcase
	end

	wire in_rd     = state_q == shp_pkg::SHP_READ;
	wire new_beat  = (state_q == shp_pkg::SHP_IDLE && rd_start)
		|| (in_rd && beat_chg && !rd_end);
	// a queue beat completes on address change or strobe release
	wire beat_done = in_rd && (rd_end || beat_chg) && addr_req_q.fifo_sel;
	wire q_beat    = sel_q;
	// burst limit depends on bus width
	wire [4:0] bmax = bus16 ? 5'(shp_pkg::BURST_MAX_16)
		: 5'(shp_pkg::BURST_MAX_32);
	// count restarts at a new cycle, stale count must not refuse beat one
	wire [4:0] beat_idx = rd_start ? 5'h0 : beats_q;
	// saturate so long queue bursts cannot wrap the count
	wire [4:0] beats_nx = (beats_q == 5'h1f) ? beats_q : beats_q + 5'h1;
	// no beat limit on queue bursts
	wire beat_ok   = q_beat || beat_idx < bmax;

	// upper half masked on 16-bit writes
	wire [DATA_W-1:0] wmask = bus16 ? {{HW{1'b0}}, {HW{1'b1}}}
		: {DATA_W{1'b1}};
	// upper half undriven on 16-bit reads
	wire [DATA_W-1:0] oe_d  = (state_d == shp_pkg::SHP_READ)
		? wmask : {DATA_W{1'b0}};
	wire [DATA_W-1:0] rdat  = addr_req_q.fifo_sel ? rxq_data : reg_rdata;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q    <= shp_pkg::SHP_IDLE;
			addr_req_q <= '0;
			beats_q    <= '0;
		end
		else
		begin
			state_q <= state_d;
			if (new_beat)
			begin
				addr_req_q <= '{fifo_sel: sel_q, addr: addr_q, half: bus16};
				beats_q    <= rd_start ? 5'h1 : beats_nx;
			end
			else if (state_q == shp_pkg::SHP_IDLE && wr_start)
				addr_req_q <= '{fifo_sel: 1'b0, addr: addr_q, half: bus16};
		end
	end

	// ---------------------------------------------------------------
	// outputs, all registered
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			data_out  <= shp_pkg::DATA_RST;
			data_oe   <= '0;
			reg_addr  <= '0;
			reg_rd    <= 1'b0;
			reg_wr    <= 1'b0;
			reg_wdata <= shp_pkg::DATA_RST;
			reg_half  <= 1'b0;
			cnt_latch <= 1'b0;
			rxq_pop   <= 1'b0;
			rxq_wsel  <= '0;
		end
		else
		begin
			data_oe   <= oe_d;
			data_out  <= rdat & wmask;
			cnt_latch <= rd_start && state_q == shp_pkg::SHP_IDLE;
			// register strobe only for non-queue beats
			reg_rd    <= new_beat && !q_beat && beat_ok;
			// queue keeps only the word-select bits
			rxq_wsel  <= addr_q[shp_pkg::WSEL_W:1];
			reg_addr  <= addr_q;
			reg_half  <= bus16;
			// one pop per completed queue beat
			rxq_pop   <= beat_done;
			// write commits at cycle end with sampled data
			reg_wr    <= state_q == shp_pkg::SHP_WRITE && wr_end;
			// last word seen while both strobes were still low
			if (state_q == shp_pkg::SHP_WRITE && wr_act)
				reg_wdata <= data_q & wmask;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_read_oe_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_start && state_q == shp_pkg::SHP_IDLE |=> data_oe[0])
		else $error("read start did not enable data drive");
	a_read_oe_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		in_rd && rd_end |=> data_oe == '0)
		else $error("data drive stayed on after read end");
	a_write_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_q == shp_pkg::SHP_WRITE && wr_end |=> reg_wr ##1 !reg_wr)
		else $error("write commit not a single pulse");
	a_upper_undrv: assert property (@(posedge ref_clk) disable iff (!rst_n)
		bus16 && $stable(bus16) |=> data_oe[DATA_W-1:HW] == '0)
		else $error("upper half driven on 16-bit bus");
	a_upper_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && reg_half |-> reg_wdata[DATA_W-1:HW] == '0)
		else $error("upper half kept on 16-bit write");
	a_queue_no_reg: assert property (@(posedge ref_clk) disable iff (!rst_n)
		new_beat && q_beat |=> !reg_rd)
		else $error("register read during queue access");
	a_cnt_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_start && state_q == shp_pkg::SHP_IDLE |=> cnt_latch)
		else $error("counters not latched at read start");
	a_pop_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rxq_pop |=> !rxq_pop)
		else $error("queue popped twice for one beat");
	a_burst_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
		reg_rd |-> beats_q <= 5'(shp_pkg::BURST_MAX_16))
		else $error("burst beat count over limit");

	c_single_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
		rd_start ##[2:20] rd_end);
	c_burst_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
		in_rd && beat_chg && !q_beat);
	c_queue_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
		rxq_pop);
	c_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
		reg_wr);
endmodule
`default_nettype wire

// ==== shp_host_model.sv ====
// host bus master model driving the sram-like host port
`timescale 1ns/1ns
`default_nettype none
module shp_host_model
(
	// clock
	input  wire logic        ref_clk,
	// resolved data bus
	input  wire logic [31:0] bus,
	// host strobes, select and address
	output logic             chip_select_n,
	output logic             read_strobe_n,
	output logic             write_strobe_n,
	output logic             fifo_sel,
	output logic [7:1]       addr,
	output logic [31:0]      drv
);
	logic [31:0] rdat [0:15];

	initial
	begin
		chip_select_n = 1'b1;
		read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		fifo_sel = 1'b0;
		addr = 7'h00;
		drv = 32'h0f0f_3c3c;
	end

	// --------------------------------------------------------
	// read, single or burst
	// --------------------------------------------------------
	// select set up with the address
	task automatic rd_burst(input logic sel, input logic [7:1] a,
		input logic [7:1] step, input int n);
		@(posedge ref_clk);
		fifo_sel <= sel;
		addr <= a;
		drv <= ~drv;
		chip_select_n <= 1'b0;
		@(posedge ref_clk);
		read_strobe_n <= 1'b0;
		// address held 8 cycles, over 45 ns
		for (int k = 0; k < n; k++)
		begin
			repeat (8) @(posedge ref_clk);
			rdat[k] = bus;
			if (k < n - 1)
				addr <= addr + step;
		end
		// select first, then strobe, high >= 13 ns
		chip_select_n <= 1'b1;
		@(posedge ref_clk);
		read_strobe_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask

	// --------------------------------------------------------
	// single write, strobe falls and rises one cycle ahead of the select
	// --------------------------------------------------------
	// both strobes low 5 cycles, data dropped as strobe rises
	task automatic wr(input logic [7:1] a, input logic [31:0] d);
		@(posedge ref_clk);
		fifo_sel <= 1'b0;
		addr <= a;
		drv <= d;
		write_strobe_n <= 1'b0;
		@(posedge ref_clk);
		chip_select_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		write_strobe_n <= 1'b1;
		drv <= ~d;
		@(posedge ref_clk);
		chip_select_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

// ==== sram_like_host_port_tb_top.sv ====
// self-checking testbench for the sram-like host port
`timescale 1ns/1ns
`default_nettype none
module sram_like_host_port_tb_top;
	logic        ref_clk, rst_n, bus16, reg_rd, reg_wr, reg_half;
	logic        chip_select_n, read_strobe_n, write_strobe_n, fifo_sel;
	logic        cnt_latch, rxq_pop;
	logic [7:1]  addr;
	logic [6:0]  reg_addr, wr_addr;
	logic [1:0]  rxq_wsel;
	logic [15:0] q_head, oe_hi;
	logic [31:0] drv, bus, data_out, data_oe, reg_wdata, reg_rdata;
	logic [31:0] rxq_data, wr_seen;
	int          err_count, tests_run, n_rd, n_pop, n_cnt, n_wr;

	// device drives bits whose enable is high, the host the rest
	assign bus = (data_oe & data_out) | (~data_oe & drv);
	assign reg_rdata = {9'h1a5, reg_addr, 9'h0c3, reg_addr};
	assign rxq_data = {16'h00f0, q_head};

	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		n_rd <= n_rd + int'(reg_rd);
		n_pop <= n_pop + int'(rxq_pop);
		n_cnt <= n_cnt + int'(cnt_latch);
		n_wr <= n_wr + int'(reg_wr);
		if (reg_wr)
		begin
			wr_seen <= reg_wdata;
			wr_addr <= reg_addr;
		end
		if (!rst_n)
			q_head <= 16'h0;
		else if (rxq_pop)
			q_head <= q_head + 16'h1;
		if (!rst_n)
			oe_hi <= 16'h0;
		else if (!chip_select_n && !read_strobe_n && bus16)
			oe_hi <= oe_hi | data_oe[31:16];
	end

	shp_host_port dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n), .fifo_sel(fifo_sel), .addr(addr),
		.data_in(bus), .data_out(data_out), .data_oe(data_oe),
		.bus16(bus16), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_half(reg_half),
		.reg_rdata(reg_rdata), .cnt_latch(cnt_latch), .rxq_data(rxq_data),
		.rxq_pop(rxq_pop), .rxq_wsel(rxq_wsel));

	shp_host_model host (.ref_clk(ref_clk), .bus(bus),
		.chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n), .fifo_sel(fifo_sel),
		.addr(addr), .drv(drv));

	// --------------------------------------------------------
	// helpers
	// --------------------------------------------------------
	function automatic logic [31:0] exp_reg(input logic [6:0] a);
		return {9'h1a5, a, 9'h0c3, a};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %0t %s: got %h want %h", $time, msg, got,
				exp);
		end
	endtask

	task automatic stop_test;
		$display("mismatches %0d of %0d checks", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// strap changes only under reset
	task automatic do_reset(input logic b16);
		rst_n <= 1'b0;
		bus16 <= b16;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
	endtask

	// --------------------------------------------------------
	// scenarios
	// --------------------------------------------------------
	task automatic t_single_read;
		int c0, r0;
		c0 = n_cnt;
		r0 = n_rd;
		host.rd_burst(1'b0, 7'h12, 7'h0, 1);
		check(host.rdat[0], exp_reg(7'h12), "single read");
		check(32'(n_cnt - c0), 32'd1, "counter latch");
		check(32'(n_rd - r0), 32'd1, "read beats");
		check(data_oe, 32'h0, "bus released");
	endtask

	task automatic t_burst_reg;
		int r0;
		r0 = n_rd;
		host.rd_burst(1'b0, 7'h20, 7'h2, 9);
		for (int k = 0; k < 8; k++)
			check(host.rdat[k], exp_reg(7'(7'h20 + 2 * k)), "burst");
		check(32'(n_rd - r0), 32'd8, "ninth beat refused");
	endtask

	task automatic t_queue;
		int r0, p0;
		logic [15:0] h0;
		r0 = n_rd;
		p0 = n_pop;
		h0 = q_head;
		host.rd_burst(1'b1, 7'h7b, 7'h08, 10);
		// last pop is counted on the edge the model returns on, so wait one more edge
		@(posedge ref_clk);
		for (int k = 0; k < 10; k++)
			check(host.rdat[k], {16'h00f0, 16'(h0 + k)}, "queue");
		check(32'(n_pop - p0), 32'd10, "one pop per beat");
		check(32'(n_rd - r0), 32'd0, "no register decode");
		check({30'h0, rxq_wsel}, 32'h3, "word select");
	endtask

	task automatic t_write(input logic [31:0] d, input logic [31:0] e);
		int w0;
		w0 = n_wr;
		host.wr(7'h34, d);
		repeat (2) @(posedge ref_clk);
		check(32'(n_wr - w0), 32'd1, "one write");
		check(wr_seen, e, "write data");
		check({25'h0, wr_addr}, 32'h34, "write address");
		check({31'h0, reg_half}, {31'h0, bus16}, "half flag");
	endtask

	task automatic t_read16;
		logic [15:0] h0;
		logic [31:0] e;
		h0 = q_head;
		e = exp_reg(7'h12);
		host.rd_burst(1'b0, 7'h12, 7'h0, 1);
		check({16'h0, host.rdat[0][15:0]}, {16'h0, e[15:0]},
			"half read");
		host.rd_burst(1'b1, 7'h05, 7'h10, 2);
		check({16'h0, host.rdat[0][15:0]}, {16'h0, h0},
			"half queue head");
		check({16'h0, host.rdat[1][15:0]}, {16'h0, 16'(h0 + 1)},
			"half queue");
		check({16'h0, oe_hi}, 32'h0, "upper half undriven");
	endtask

	initial
	begin
		rst_n = 1'b0;
		bus16 = 1'b0;
		do_reset(1'b0);
		t_single_read();
		t_burst_reg();
		t_queue();
		t_write(32'h1234_5678, 32'h1234_5678);
		do_reset(1'b1);
		t_read16();
		t_write(32'hdead_beef, 32'h0000_beef);
		stop_test();
	end
endmodule
`default_nettype wire
